// File: verilog/preproc_pkg.sv
/*
 Constants of the preprocessed control and signaling channel handler:
 control memory layout, channel codes, change FIFO size and last-look timing.
 Assumes a 50 MHz core clock.
*/
// Overview of operation
// - latest received signaling stored as even actual
// - odd stable updated only on confirmed change
// - stable change raises irq, queues address
// - double last-look with programmable sampling period
// - monitor protocol selectable; non-handshake for slot bus
// - idle downstream bits: float if 0, one if 1
// - command/indication exchanged; upstream change queued
// - central scheme passes two D bits transparently
// - downstream monitor bits: memory data, ANDed with handler bits in handshake mode
// - nine-entry FIFO; overflow changes wait at interface
// - period 125 us if rate bit, else (1+value)*250 us
// - irq stays while FIFO holds entries
package preproc_pkg;
    localparam int N_SUB = 8;
    localparam int SUB_W = 3;
    localparam int ENT_W = 5;
    localparam int N_ENT = 32;
    localparam int SUB_LSB = 1;
    localparam int SEL_LSB = 6;
    localparam logic [1:0] SEL_DN_EVEN = 2'h0;
    localparam logic [1:0] SEL_DN_ODD = 2'h1;
    localparam logic [1:0] SEL_UP_EVEN = 2'h2;
    localparam logic [1:0] SEL_UP_ODD = 2'h3;
    localparam logic [3:0] MOC_WR_ALL = 4'h7;
    localparam logic [3:0] MOC_WR_DATA = 4'h9;
    localparam logic [3:0] CODE_CI_UP = 4'h8;
    localparam logic [3:0] CODE_CS_EVEN = 4'hA;
    localparam logic [3:0] CODE_CS_ODD = 4'hB;
    localparam logic [1:0] CODE_SUBSLOT_HI = 2'h1;
    localparam logic [3:0] CM_CODE_RST = 4'h0;
    localparam logic [7:0] CM_DATA_RST = 8'hFF;
    localparam logic [7:0] MASK_SIG6 = 8'hFC;
    localparam logic [7:0] MASK_SIG8 = 8'hFF;
    localparam int CI_MSB = 5;
    localparam int CI_LSB = 2;
    localparam int FIFO_DEPTH = 9;
    localparam int FIFO_W = 7;
    localparam int TIMER_PERIOD_VALUE_W = 7;
    localparam int UNIT_W = 14;
    localparam int CLK_PERIOD_NS = 20;
    localparam int LL_UNIT_NS = 250000;
    localparam int LL_UNIT_CYC_DEF = LL_UNIT_NS / CLK_PERIOD_NS;
endpackage : preproc_pkg

// File: verilog/change_fifo.sv
/*
 Change-address FIFO with valid/ready on both sides and synchronous clear.
 Assumes writer and reader share core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module change_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 9
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;

    wire do_push = in_valid_i && in_ready_o;
    wire do_pop = out_valid_o && out_ready_i;
    // a push in the clearing cycle survives in slot 0
    wire [PTR_W-1:0] wr_slot = clear_i ? '0 : wr_ptr;

    assign in_ready_o = count != CNT_FULL;
    assign out_valid_o = count != '0;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge core_clk_i) begin
        if (do_push) begin
            mem[wr_slot] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clear_i) begin
            wr_ptr <= do_push ? PTR_W'(1) : '0;
            rd_ptr <= '0;
            count <= CNT_W'(do_push);
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_fifo_bound: assert property (count <= CNT_FULL)
        else $error("fifo count above depth");
endmodule : change_fifo
`default_nettype wire

// File: verilog/preproc_channel_handler.sv
/*
 Preprocessed channel handler: control memory, upstream change detection
 with double last-look, change-address queue and downstream slot builder.
 Assumes per-slot byte strobes from a serializer on core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module preproc_channel_handler #(
    parameter int LL_UNIT_CYC = preproc_pkg::LL_UNIT_CYC_DEF
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // memory access
    input wire logic ma_wr_i,
    input wire logic ma_rd_i,
    input wire logic [7:0] memory_access_address_i,
    input wire logic [7:0] memory_access_control_i,
    input wire logic [7:0] memory_access_data_i,
    output logic [7:0] ma_rdata_o,
    // upstream odd slot
    input wire logic up_strobe_i,
    input wire logic [preproc_pkg::SUB_W-1:0] up_sub_i,
    input wire logic [7:0] up_byte_i,
    // downstream odd slot
    input wire logic dn_strobe_i,
    input wire logic [preproc_pkg::SUB_W-1:0] dn_sub_i,
    output logic [7:0] dn_byte_o,
    output logic [7:0] dn_drive_n_o,
    // d channel to and from pcm side
    input wire logic [1:0] pcm_d_i,
    output logic [1:0] d_up_o,
    output logic d_up_valid_o,
    // monitor handler
    input wire logic [1:0] mf_bits_i,
    input wire logic mf_handshake_i,
    // configuration
    input wire logic idle_subslot_level_select_i,
    input wire logic [preproc_pkg::N_SUB-1:0] decentral_sel_i,
    input wire logic sampling_rate_select_i,
    input wire logic [preproc_pkg::TIMER_PERIOD_VALUE_W-1:0] timer_period_value_i,
    input wire logic timer_start_i,
    input wire logic frame_i,
    output logic timer_active_o,
    // change queue
    input wire logic cfifo_rd_i,
    input wire logic cfifo_reset_i,
    output logic [7:0] change_address_fifo_o,
    output logic signaling_fifo_irq_o
);
    import preproc_pkg::*;

    logic [3:0] cm_code [0:N_ENT-1];
    logic [7:0] cm_data [0:N_ENT-1];
    logic due [0:N_SUB-1];
    logic [7:0] ll_prev [0:N_SUB-1];
    logic [UNIT_W-1:0] unit_cnt;
    logic [TIMER_PERIOD_VALUE_W-1:0] tv_cnt;
    logic push_r;
    logic [FIFO_W-1:0] fifo_q;

    // memory access decode
    wire [ENT_W-1:0] ma_idx = {memory_access_address_i[7:SEL_LSB], memory_access_address_i[SUB_LSB+:SUB_W]};
    wire sw_all = ma_wr_i && memory_access_control_i[7:4] == MOC_WR_ALL;
    wire sw_data = ma_wr_i && memory_access_control_i[7:4] == MOC_WR_DATA;

    // upstream scheme selection
    wire [ENT_W-1:0] ue = {SEL_UP_EVEN, up_sub_i};
    wire [ENT_W-1:0] uo = {SEL_UP_ODD, up_sub_i};
    wire [3:0] uc_e = cm_code[ue];
    wire [3:0] uc_o = cm_code[uo];
    wire ci_sel = up_strobe_i && uc_e == CODE_CI_UP;
    wire ci_chg = ci_sel && up_byte_i[CI_MSB:CI_LSB] != cm_data[ue][CI_MSB:CI_LSB];
    wire sig6 = uc_e == CODE_CS_EVEN && uc_o == CODE_CS_EVEN;
    wire sig8 = uc_e == CODE_CS_ODD && uc_o == CODE_CS_ODD;
    wire sig_sel = up_strobe_i && (sig6 || sig8);
    wire [7:0] sig_mask = sig8 ? MASK_SIG8 : MASK_SIG6;
    wire [7:0] act = up_byte_i & sig_mask;
    wire ll_chk = sig_sel && due[up_sub_i];
    // double last look: two equal samples differing from stable
    wire ll_chg = ll_chk && act == ll_prev[up_sub_i] && act != (cm_data[uo] & sig_mask);
    wire push_v = ci_chg || ll_chg;
    wire push_ok = push_v && push_r;
    wire sad_odd = !ci_chg;
    wire [FIFO_W-1:0] sad = {sad_odd, 2'h0, up_sub_i, sad_odd};

    // last-look period
    wire unit_done = unit_cnt == UNIT_W'(LL_UNIT_CYC - 1);
    wire tv_done = tv_cnt == timer_period_value_i;
    wire timer_tick = timer_active_o && unit_done && tv_done;
    wire ll_tick = sampling_rate_select_i ? frame_i : timer_tick;

    // downstream slot build
    wire [ENT_W-1:0] de = {SEL_DN_EVEN, dn_sub_i};
    wire [ENT_W-1:0] dodd = {SEL_DN_ODD, dn_sub_i};
    wire dn_even_ok = cm_code[de] == CODE_CS_EVEN;
    wire dn_cs = dn_even_ok && cm_code[dodd] == CODE_CS_ODD;
    wire dn_cen = dn_even_ok && cm_code[dodd][3:2] == CODE_SUBSLOT_HI;
    wire dn_dec = dn_cs && decentral_sel_i[dn_sub_i];
    wire dn_sig8 = cm_code[{SEL_UP_EVEN, dn_sub_i}] == CODE_CS_ODD;
    wire [1:0] mon = mf_handshake_i ? mf_bits_i : 2'h3;
    wire [7:0] dd = cm_data[de];
    wire [1:0] dn_mon = dd[1:0] & mon;
    wire [1:0] dn_top = dn_cen ? pcm_d_i : (dn_dec ? {2{idle_subslot_level_select_i}} : dd[7:6]);
    wire [7:0] next_dn_byte = (dn_sig8 && !dn_cen) ? dd : {dn_top, dd[CI_MSB:CI_LSB], dn_mon};
    wire [7:0] next_dn_drive_n = !(dn_cs || dn_cen) ? 8'hFF :
        (dn_dec && !idle_subslot_level_select_i) ? 8'hC0 : 8'h00;

    change_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(cfifo_reset_i),
        .in_valid_i(push_v),
        .in_ready_o(push_r),
        .in_data_i(sad),
        .out_valid_o(signaling_fifo_irq_o),
        .out_ready_i(cfifo_rd_i),
        .out_data_o(fifo_q)
    );
    assign change_address_fifo_o = {signaling_fifo_irq_o, fifo_q};

    // control memory
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N_ENT; i++) begin
                cm_code[i] <= CM_CODE_RST;
                cm_data[i] <= CM_DATA_RST;
            end
        end else begin
            if (ci_chg && push_r) begin
                cm_data[ue][CI_MSB:CI_LSB] <= up_byte_i[CI_MSB:CI_LSB];
            end
            if (sig_sel) begin
                cm_data[ue] <= act;
            end
            if (ll_chg && push_r) begin
                cm_data[uo] <= act;
            end
            if (sw_all) begin
                cm_code[ma_idx] <= memory_access_control_i[3:0];
                cm_data[ma_idx] <= memory_access_data_i;
            end else if (sw_data) begin
                cm_data[ma_idx] <= memory_access_data_i;
            end
        end
    end

    // per-subscriber last-look state
    for (genvar s = 0; s < N_SUB; s++) begin : g_sub
        wire hit = up_sub_i == SUB_W'(s);
        always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                due[s] <= 1'b0;
                ll_prev[s] <= 8'h00;
            end else begin
                if (ll_tick) begin
                    due[s] <= 1'b1;
                end else if (ll_chk && hit && (!ll_chg || push_r)) begin
                    due[s] <= 1'b0;
                end
                if (ll_chk && hit) begin
                    ll_prev[s] <= act;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_active_o <= 1'b0;
            unit_cnt <= '0;
            tv_cnt <= '0;
        end else if (timer_start_i) begin
            timer_active_o <= 1'b1;
            unit_cnt <= '0;
            tv_cnt <= '0;
        end else if (timer_active_o) begin
            unit_cnt <= unit_done ? '0 : unit_cnt + 1'b1;
            if (unit_done) begin
                tv_cnt <= tv_done ? '0 : tv_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ma_rdata_o <= 8'h00;
            dn_byte_o <= 8'hFF;
            dn_drive_n_o <= 8'hFF;
            d_up_o <= 2'h3;
            d_up_valid_o <= 1'b0;
        end else begin
            if (ma_rd_i) begin
                ma_rdata_o <= cm_data[ma_idx];
            end
            if (dn_strobe_i) begin
                dn_byte_o <= next_dn_byte;
                dn_drive_n_o <= next_dn_drive_n;
            end
            d_up_valid_o <= ci_sel && uc_o[3:2] == CODE_SUBSLOT_HI;
            if (ci_sel && uc_o[3:2] == CODE_SUBSLOT_HI) begin
                d_up_o <= up_byte_i[7:6];
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_actual_store: assert property (sig_sel && !sw_all && !sw_data |=> cm_data[$past(ue)] == $past(act))
        else $error("actual value not stored");
    chk_stable_update: assert property (ll_chg && push_r && !sw_all && !sw_data
        |=> cm_data[$past(uo)] == $past(act))
        else $error("stable value not updated");
    chk_stable_hold: assert property (sig_sel && !ll_chg && !sw_all && !sw_data
        |=> cm_data[$past(uo)] == $past(cm_data[uo]))
        else $error("stable value moved without change");
    chk_change_irq: assert property (push_v && push_r && !cfifo_reset_i |=> signaling_fifo_irq_o)
        else $error("irq missing after change");
    chk_tick_due: assert property (sampling_rate_select_i && frame_i |=> due[$past(up_sub_i)])
        else $error("frame tick did not arm sampling");
    chk_idle_float: assert property (dn_strobe_i && dn_dec && !idle_subslot_level_select_i
        |=> dn_drive_n_o[7:6] == 2'h3 && dn_drive_n_o[5:0] == 6'h00)
        else $error("idle bits not floated");
    chk_ci_capture: assert property (ci_chg && push_r && !sw_all && !sw_data
        |=> cm_data[$past(ue)][CI_MSB:CI_LSB] == $past(up_byte_i[CI_MSB:CI_LSB]))
        else $error("command value not captured");
    chk_d_pass: assert property (dn_strobe_i && dn_cen |=> dn_byte_o[7:6] == $past(pcm_d_i))
        else $error("d bits not passed");
    chk_mon_ones: assert property (dn_strobe_i && dn_cs && !dn_sig8 && !mf_handshake_i
        |=> dn_byte_o[1:0] == $past(dd[1:0]))
        else $error("monitor bits altered");
    chk_pending_hold: assert property (ci_chg && !push_r && !sw_all && !sw_data
        |=> cm_data[$past(ue)] == $past(cm_data[ue]))
        else $error("change written while queue full");
    chk_irq_clear: assert property (cfifo_reset_i && !(push_v && push_r) |=> !signaling_fifo_irq_o)
        else $error("irq survives queue reset");
    chk_dn_repeat: assert property (dn_strobe_i && !sw_all && !sw_data ##1 dn_strobe_i && $stable(dn_sub_i)
        && $stable(pcm_d_i) && $stable(mf_bits_i) && $stable(mf_handshake_i)
        && $stable(idle_subslot_level_select_i) && $stable(decentral_sel_i) |=> $stable(dn_byte_o))
        else $error("downstream value not repeated");

    cov_ci_change: cover property (ci_chg && push_r);
    cov_sig_change: cover property (ll_chg && push_r);
    cov_queue_full: cover property (push_v && !push_r);
    cov_central: cover property (dn_strobe_i && dn_cen);
endmodule : preproc_channel_handler
`default_nettype wire

// File: tb/subscriber_model.sv
/*
 Subscriber-side model: hands one upstream odd-slot byte per strobe.
 Assumes the handler samples on the rising edge of core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module subscriber_model (
    // clock
    input wire logic core_clk_i,
    // upstream slot toward the handler
    output logic up_strobe_o,
    output logic [preproc_pkg::SUB_W-1:0] up_sub_o,
    output logic [7:0] up_byte_o
);
    import preproc_pkg::*;
    initial begin
        up_strobe_o = 1'b0;
        up_sub_o = 3'h0;
        up_byte_o = 8'h00;
    end
    // released line shows the inverse of the last byte
    task automatic send(input logic [SUB_W-1:0] s, input logic [7:0] b);
        @(posedge core_clk_i);
        up_strobe_o <= 1'b1;
        up_sub_o <= s;
        up_byte_o <= b;
        @(posedge core_clk_i);
        up_strobe_o <= 1'b0;
        up_byte_o <= ~b;
    endtask : send
endmodule : subscriber_model
`default_nettype wire

// File: tb/testbench.sv
/*
 Self-checking bench of the preprocessed channel handler.
 Assumes subscriber_model on the upstream side and a 10-cycle timer unit.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import preproc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ma_wr = 1'b0, ma_rd = 1'b0, dn_stb = 1'b0, mf_hs = 1'b0, idle_sel = 1'b0, rate = 1'b0;
    logic frame = 1'b0, tstart = 1'b0, cf_rd = 1'b0, cf_rst = 1'b0, up_stb, irq, tact, dup_v;
    logic [7:0] addr = 8'h00, ctrl = 8'h00, wdata = 8'h00, dsel = 8'h00, up_byte;
    logic [7:0] rdata, dn_byte, dn_drv, cfo;
    logic [2:0] dn_sub = 3'h0, up_sub;
    logic [1:0] pcm_d = 2'h0, mf_bits = 2'h0, d_up;
    logic [6:0] timer_period_value = 7'h00;
    int mismatches = 0, compares = 0, cycles = 0;
    always #10 clk = ~clk;
    subscriber_model sub_model (.core_clk_i(clk), .up_strobe_o(up_stb), .up_sub_o(up_sub), .up_byte_o(up_byte));
    preproc_channel_handler #(.LL_UNIT_CYC(10)) DUT (
        .core_clk_i(clk), .rst_n_i(rst_n), .ma_wr_i(ma_wr), .ma_rd_i(ma_rd),
        .memory_access_address_i(addr), .memory_access_control_i(ctrl), .memory_access_data_i(wdata),
        .ma_rdata_o(rdata), .up_strobe_i(up_stb), .up_sub_i(up_sub), .up_byte_i(up_byte),
        .dn_strobe_i(dn_stb), .dn_sub_i(dn_sub), .dn_byte_o(dn_byte), .dn_drive_n_o(dn_drv),
        .pcm_d_i(pcm_d), .d_up_o(d_up), .d_up_valid_o(dup_v), .mf_bits_i(mf_bits), .mf_handshake_i(mf_hs),
        .idle_subslot_level_select_i(idle_sel), .decentral_sel_i(dsel), .sampling_rate_select_i(rate),
        .timer_period_value_i(timer_period_value), .timer_start_i(tstart), .frame_i(frame), .timer_active_o(tact),
        .cfifo_rd_i(cf_rd), .cfifo_reset_i(cf_rst), .change_address_fifo_o(cfo), .signaling_fifo_irq_o(irq));
    task automatic complete_run();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [1:0] q, input logic [2:0] s, input logic [7:0] c, input logic [7:0] d);
        @(posedge clk);
        ma_wr <= 1'b1;
        addr <= {q, 2'b00, s, 1'b0};
        ctrl <= c;
        wdata <= d;
        @(posedge clk);
        ma_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] q, input logic [2:0] s);
        @(posedge clk);
        ma_rd <= 1'b1;
        addr <= {q, 2'b00, s, 1'b0};
        @(posedge clk);
        ma_rd <= 1'b0;
        cyc(1);
    endtask : rd
    task automatic dn(input logic [2:0] s);
        @(posedge clk);
        dn_stb <= 1'b1;
        dn_sub <= s;
        @(posedge clk);
        dn_stb <= 1'b0;
        cyc(1);
    endtask : dn
    // 0 frame, 1 timer start, 2 pop, 3 queue clear
    task automatic pulse(input int w);
        @(posedge clk);
        frame <= (w == 0);
        tstart <= (w == 1);
        cf_rd <= (w == 2);
        cf_rst <= (w == 3);
        @(posedge clk);
        {frame, tstart, cf_rd, cf_rst} <= 4'h0;
        cyc(2);
    endtask : pulse
    function automatic logic [7:0] head(input logic odd, input logic [2:0] s);
        return {1'b1, odd, 2'b00, s, odd};
    endfunction : head
    task automatic t_rw();
        for (int q = 0; q < 4; q++) begin
            wr(q[1:0], 3'h7, {MOC_WR_ALL, CODE_CS_EVEN}, 8'h10 + 8'(q));
        end
        wr(SEL_DN_EVEN, 3'h7, 8'h5A, 8'hEE);
        for (int q = 0; q < 4; q++) begin
            rd(q[1:0], 3'h7);
            chk("quadrant data", 8'h10 + 8'(q), rdata);
        end
    endtask : t_rw
    task automatic t_dn_sig();
        wr(SEL_DN_EVEN, 3'h0, {MOC_WR_ALL, CODE_CS_EVEN}, 8'h47);
        wr(SEL_DN_ODD, 3'h0, {MOC_WR_ALL, CODE_CS_ODD}, 8'h00);
        repeat (2) begin
            dn(3'h0);
            chk("dn byte", 8'h47, dn_byte);
            chk("dn drive", 8'h00, dn_drv);
        end
        @(posedge clk);
        dn_stb <= 1'b1;
        repeat (2) @(posedge clk);
        dn_stb <= 1'b0;
        cyc(1);
        chk("dn repeat burst", 8'h47, dn_byte);
        wr(SEL_DN_EVEN, 3'h0, {MOC_WR_DATA, 4'h0}, 8'h9B);
        mf_hs <= 1'b1;
        mf_bits <= 2'b01;
        dn(3'h0);
        chk("dn monitor bits", 8'h99, dn_byte);
        mf_hs <= 1'b0;
    endtask : t_dn_sig
    task automatic t_dn_idle();
        wr(SEL_DN_EVEN, 3'h5, {MOC_WR_ALL, CODE_CS_EVEN}, 8'h03);
        wr(SEL_DN_ODD, 3'h5, {MOC_WR_ALL, CODE_CS_ODD}, 8'h00);
        dsel <= 8'h20;
        dn(3'h5);
        chk("idle float drive", 8'hC0, dn_drv);
        chk("idle float low", 8'h03, dn_byte & 8'h3F);
        idle_sel <= 1'b1;
        dn(3'h5);
        chk("idle one byte", 8'hC3, dn_byte);
        chk("idle one drive", 8'h00, dn_drv);
        dn(3'h6);
        chk("unset drive", 8'hFF, dn_drv);
    endtask : t_dn_idle
    task automatic t_central();
        wr(SEL_DN_EVEN, 3'h4, {MOC_WR_ALL, CODE_CS_EVEN}, 8'h03);
        wr(SEL_DN_ODD, 3'h4, {MOC_WR_ALL, 4'h7}, 8'h00);
        wr(SEL_UP_EVEN, 3'h4, {MOC_WR_ALL, CODE_CI_UP}, 8'hFF);
        wr(SEL_UP_ODD, 3'h4, {MOC_WR_ALL, 4'h7}, 8'h00);
        pcm_d <= 2'b10;
        dn(3'h4);
        chk("central dn byte", 8'h83, dn_byte);
        sub_model.send(3'h4, 8'h7F);
        cyc(0);
        chk("central up valid", 8'h01, {7'h00, dup_v});
        cyc(2);
        chk("central up d", 8'h01, {6'h00, d_up});
        chk("central up valid end", 8'h00, {7'h00, dup_v});
        chk("central irq", 8'h00, {7'h00, irq});
    endtask : t_central
    task automatic t_ci();
        wr(SEL_UP_EVEN, 3'h1, {MOC_WR_ALL, CODE_CI_UP}, 8'hFF);
        wr(SEL_UP_ODD, 3'h1, {MOC_WR_ALL, 4'h0}, 8'h00);
        sub_model.send(3'h1, 8'hC3);
        cyc(2);
        chk("ci irq", 8'h01, {7'h00, irq});
        chk("ci head", head(1'b0, 3'h1), cfo);
        rd(SEL_UP_EVEN, 3'h1);
        chk("ci value", 8'hC3, rdata);
        pulse(2);
        chk("ci irq clear", 8'h00, {7'h00, irq});
    endtask : t_ci
    task automatic t_full();
        for (int i = 0; i < 9; i++) begin
            sub_model.send(3'h1, i[0] ? 8'hC3 : 8'hFF);
        end
        sub_model.send(3'h1, 8'hC3);
        cyc(2);
        chk("full head", head(1'b0, 3'h1), cfo);
        rd(SEL_UP_EVEN, 3'h1);
        chk("blocked value", 8'hFF, rdata);
        pulse(2);
        sub_model.send(3'h1, 8'hC3);
        cyc(2);
        rd(SEL_UP_EVEN, 3'h1);
        chk("pending value", 8'hC3, rdata);
        pulse(3);
        chk("clear irq", 8'h00, {7'h00, irq});
    endtask : t_full
    task automatic t_timer();
        wr(SEL_UP_EVEN, 3'h3, {MOC_WR_ALL, CODE_CS_ODD}, 8'hFF);
        wr(SEL_UP_ODD, 3'h3, {MOC_WR_ALL, CODE_CS_ODD}, 8'hFF);
        wr(SEL_DN_EVEN, 3'h3, {MOC_WR_ALL, CODE_CS_EVEN}, 8'h45);
        wr(SEL_DN_ODD, 3'h3, {MOC_WR_ALL, CODE_CS_ODD}, 8'h00);
        mf_hs <= 1'b1;
        mf_bits <= 2'b00;
        dn(3'h3);
        chk("sig8 dn byte", 8'h45, dn_byte);
        mf_hs <= 1'b0;
        timer_period_value <= 7'h01;
        chk("timer idle", 8'h00, {7'h00, tact});
        pulse(1);
        chk("timer active", 8'h01, {7'h00, tact});
        sub_model.send(3'h3, 8'h5A);
        sub_model.send(3'h3, 8'h5A);
        cyc(2);
        chk("before period", 8'h00, {7'h00, irq});
        cyc(20);
        sub_model.send(3'h3, 8'h5A);
        cyc(2);
        chk("one timer look", 8'h00, {7'h00, irq});
        cyc(10);
        sub_model.send(3'h3, 8'h5A);
        cyc(2);
        chk("timer head", head(1'b1, 3'h3), cfo);
        rd(SEL_UP_ODD, 3'h3);
        chk("stable 8bit", 8'h5A, rdata);
        pulse(2);
    endtask : t_timer
    task automatic t_sig6();
        wr(SEL_UP_EVEN, 3'h2, {MOC_WR_ALL, CODE_CS_EVEN}, 8'hFF);
        wr(SEL_UP_ODD, 3'h2, {MOC_WR_ALL, CODE_CS_EVEN}, 8'hFF);
        rate <= 1'b1;
        sub_model.send(3'h2, 8'h54);
        pulse(0);
        sub_model.send(3'h2, 8'h58);
        cyc(2);
        chk("single look", 8'h00, {7'h00, irq});
        rd(SEL_UP_EVEN, 3'h2);
        chk("actual value", 8'h58, rdata & MASK_SIG6);
        pulse(0);
        sub_model.send(3'h2, 8'h58);
        cyc(2);
        chk("sig6 head", head(1'b1, 3'h2), cfo);
        rd(SEL_UP_ODD, 3'h2);
        chk("stable 6bit", 8'h58, rdata & MASK_SIG6);
    endtask : t_sig6
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        chk("reset irq", 8'h00, {7'h00, irq});
        chk("reset dn byte", 8'hFF, dn_byte);
        chk("reset queue", 8'h00, cfo & 8'h80);
        t_rw();
        t_dn_sig();
        t_dn_idle();
        t_central();
        t_ci();
        t_full();
        t_timer();
        t_sig6();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
